// ==== hdl/tmi_pkg.sv ====
// Shared constants and carrier types for the thermal monitor interrupt logic
package tmi_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_MAIN_CFG   = 8'h00;
    localparam logic [7:0] ADDR_PIN_CFG3   = 8'h07;
    localparam logic [7:0] ADDR_THERMAL_ALARM_N_LIM0 = 8'h0D;
    localparam logic [7:0] ADDR_THERMAL_ALARM_N_LIM1 = 8'h0E;
    localparam logic [7:0] ADDR_THERMAL_ALARM_N_LIM2 = 8'h0F;
    localparam logic [7:0] ADDR_STATUS1    = 8'h20;
    localparam logic [7:0] ADDR_STATUS4    = 8'h23;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int CFG_INT_EN      = 1;
    localparam int CFG_INT_CLR     = 2;
    localparam int CFG_THERMAL_ALARM_N_EN    = 4;
    localparam int CFG3_PIN16_GP   = 0;
    localparam int CFG3_CASE_CLR   = 1;
    localparam int ST4_THERMAL_ALARM_N_CHG   = 3;
    localparam int ST4_FAN_EVT     = 4;
    localparam int ST4_CASE        = 6;
    localparam int ST4_PIN16       = 7;
    localparam int AN_SR4_BASE     = 16;
    localparam int AN_CH2_BIT      = 16;
    localparam int AN_CH1_BIT      = 1;
    localparam int AN_CH0_BIT      = 0;
    localparam logic [7:0] MAIN_CFG_RST  = 8'h00;
    localparam logic [7:0] PIN_CFG3_RST  = 8'h00;
    localparam logic [7:0] THERMAL_ALARM_N_LIM_RST = 8'h64;

    // ****************************************************************
    // Sizes and counts
    // ****************************************************************
    localparam int N_AN      = 24;
    localparam int N_FAN     = 8;
    localparam int N_GP      = 17;
    localparam int PIN16     = 16;
    localparam logic [8:0] THERMAL_ALARM_N_HYST      = 9'd5;
    localparam logic [1:0] LOCAL_TEMP_WAIT = 2'd2;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic       valid;
        logic [4:0] index;
        logic [7:0] value;
        logic [7:0] high;
        logic [7:0] low;
    } tmi_meas_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] index;
        logic [7:0] count;
        logic [7:0] limit;
    } tmi_fan_s;
endpackage : tmi_pkg

// ==== hdl/tmi_thermal_monitor_interrupt.sv ====
// Interrupt aggregation and thermal alarm logic of the hardware monitor
`timescale 1ns/10ps

module tmi_thermal_monitor_interrupt (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Register access port
    input  wire logic              reg_sel_i,
    input  wire logic              reg_we_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic              alert_response_i,
    // Measurement side
    input  wire tmi_pkg::tmi_meas_s meas_i,
    input  wire tmi_pkg::tmi_fan_s  fan_i,
    input  wire logic              local_temp_done_i,
    input  wire logic              monitor_cycle_i,
    input  wire logic              fan_cycle_end_i,
    input  wire logic              automatic_fan_regulation_i,
    input  wire logic              fan_start_stop_i,
    input  wire logic              temp_valid_i,
    input  wire logic [23:0]       temp_i,
    // Masks and pin setup
    input  wire logic [23:0]       analog_mask_i,
    input  wire logic [7:0]        fan_mask_i,
    input  wire logic [16:0]       general_mask_i,
    input  wire logic [16:0]       general_dir_out_i,
    input  wire logic [16:0]       general_polarity_i,
    // Pins
    input  wire logic [16:0]       general_pin_i,
    input  wire logic              case_open_input_i,
    input  wire logic              thermal_alarm_n_i,
    output logic                   thermal_alarm_n_o,
    output logic                   thermal_alarm_n_oe_n_o,
    output logic                   int_n_o,
    output logic                   cooling_full_o,
    // Status views
    output logic [23:0]            analog_status_o,
    output logic [7:0]             fan_status_o,
    output logic [16:0]            general_status_o
);
    import tmi_pkg::*;

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic [7:0]       main_configuration;
    logic [7:0]       pin_configuration_three;
    logic [7:0]       thermal_limit [3];
    logic [N_AN-1:0]  an_st;
    logic [N_FAN-1:0] fan_st;
    logic             thermal_alarm_n_chg_st;
    logic             fan_evt_st;
    logic             case_st;
    logic             an_latch;
    logic             fan_latch;
    logic             evt_latch;
    logic [1:0]       an_wait;
    logic             fan_hold;
    logic             thermal_alarm_n_active;
    logic [1:0]       gp_s1 [N_GP];
    logic [N_GP-1:0]  gp_sync;
    logic [1:0]       case_s;
    logic [1:0]       thermal_alarm_n_s;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            case_s  <= 2'h0;
            thermal_alarm_n_s <= 2'h3;
        end else if (ce_i) begin
            case_s  <= {case_s[0], case_open_input_i};
            thermal_alarm_n_s <= {thermal_alarm_n_s[0], thermal_alarm_n_i};
        end
    end

    for (genvar g = 0; g < N_GP; g++) begin : g_sync
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                gp_s1[g] <= 2'h0;
            end else if (ce_i) begin
                gp_s1[g] <= {gp_s1[g][0], general_pin_i[g]};
            end
        end
        assign gp_sync[g] = gp_s1[g][1];
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire wr_main  = reg_sel_i && reg_we_i && reg_addr_i == ADDR_MAIN_CFG;
    wire wr_cfg3  = reg_sel_i && reg_we_i && reg_addr_i == ADDR_PIN_CFG3;
    wire rd_st1   = reg_sel_i && !reg_we_i && reg_addr_i == ADDR_STATUS1;
    wire pin16_gp = pin_configuration_three[CFG3_PIN16_GP];
    wire case_clr = pin_configuration_three[CFG3_CASE_CLR];
    wire int_clr  = main_configuration[CFG_INT_CLR];
    // Clear bit is a level: an_latch and fan_latch stay reset while it is high; evt_latch can still be set
    wire clear_any = rd_st1 || alert_response_i || int_clr;

    // Out-of-limit test for a measurement result
    function automatic logic out_of_limit(input logic [7:0] v, input logic [7:0] hi,
                                          input logic [7:0] lo);
        out_of_limit = (v > hi) || (v <= lo);
    endfunction : out_of_limit

    wire meas_out = out_of_limit(meas_i.value, meas_i.high, meas_i.low);
    wire fan_out  = fan_i.count > fan_i.limit;

    // ****************************************************************
    // Thermal alarm with fixed hysteresis
    // ****************************************************************
    logic [2:0] t_over;
    logic [2:0] t_cool;
    for (genvar s = 0; s < 3; s++) begin : g_thermal_alarm_n
        wire [7:0] t = temp_i[8*s +: 8];
        assign t_over[s] = t > thermal_limit[s];
        assign t_cool[s] = ({1'b0, t} + THERMAL_ALARM_N_HYST) <= {1'b0, thermal_limit[s]};
    end
    wire thermal_alarm_n_set   = temp_valid_i && !thermal_alarm_n_active && |t_over;
    wire thermal_alarm_n_rel   = temp_valid_i && thermal_alarm_n_active && &t_cool;
    wire thermal_alarm_n_chg   = thermal_alarm_n_set || thermal_alarm_n_rel;
    // Own drive reaches the synchroniser late; a recent drive is not foreign
    logic [2:0] own_hist;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            own_hist <= 3'h0;
        end else if (ce_i) begin
            own_hist <= {own_hist[1:0], !thermal_alarm_n_oe_n_o};
        end
    end

    // Our own drive is excluded so only a foreign low counts
    wire ext_low     = !pin16_gp && !thermal_alarm_n_s[1] && !thermal_alarm_n_active &&
                       own_hist == 3'h0;

    // Channel that triggered a set, or channel 0 on release, mapped onto its status bit
    logic [N_AN-1:0] chg_bits;
    always_comb begin
        chg_bits = '0;
        if (thermal_alarm_n_chg) begin
            chg_bits[AN_CH0_BIT] = thermal_alarm_n_set ? t_over[0] : 1'b1;
            chg_bits[AN_CH1_BIT] = thermal_alarm_n_set ? t_over[1] : 1'b0;
            chg_bits[AN_CH2_BIT] = thermal_alarm_n_set ? t_over[2] : 1'b0;
        end
    end

    // ****************************************************************
    // Measurement status next values
    // ****************************************************************
    logic [N_AN-1:0]  next_an_st;
    logic [N_FAN-1:0] next_fan_st;
    always_comb begin
        next_an_st = an_st;
        if (rd_st1) begin
            next_an_st = '0;
        end
        if (meas_i.valid) begin
            next_an_st[meas_i.index] = meas_out;
        end
        next_an_st = next_an_st | chg_bits;
        next_fan_st = rd_st1 ? '0 : fan_st;
        if (fan_i.valid) begin
            next_fan_st[fan_i.index] = fan_out;
        end
    end

    // ****************************************************************
    // Gating of each group
    // ****************************************************************
    wire an_pend  = |(an_st & ~analog_mask_i);
    wire fan_pend = |(fan_st & ~fan_mask_i);
    wire [N_GP-1:0] gp_assert = ~(gp_sync ^ general_polarity_i);
    logic [N_GP-1:0] gp_live;
    always_comb begin
        gp_live = gp_assert & ~general_dir_out_i;
        gp_live[PIN16] = gp_assert[PIN16] && pin16_gp;
    end
    logic [N_GP-1:0] gp_mask;
    always_comb begin
        gp_mask = general_mask_i | general_dir_out_i;
        gp_mask[PIN16] = general_mask_i[PIN16];
    end
    // Pin and case sources stay unlatched so status reads and alert responses cannot hide them
    wire direct_pend = |(gp_live & ~gp_mask) ||
                       (case_st && !analog_mask_i[AN_SR4_BASE + ST4_CASE]);
    wire evt_src = (thermal_alarm_n_chg && !analog_mask_i[AN_SR4_BASE + ST4_THERMAL_ALARM_N_CHG]) ||
                   (fan_start_stop_i && automatic_fan_regulation_i &&
                    !analog_mask_i[AN_SR4_BASE + ST4_FAN_EVT]);
    wire int_on = main_configuration[CFG_INT_EN] && !int_clr &&
                  (an_latch || fan_latch || evt_latch || direct_pend);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            main_configuration      <= MAIN_CFG_RST;
            pin_configuration_three <= PIN_CFG3_RST;
            for (int i = 0; i < 3; i++) begin
                thermal_limit[i] <= THERMAL_ALARM_N_LIM_RST;
            end
        end else if (ce_i && reg_sel_i && reg_we_i) begin
            if (wr_main) begin
                main_configuration <= reg_wdata_i;
            end
            if (wr_cfg3) begin
                pin_configuration_three <= reg_wdata_i;
            end
            for (int i = 0; i < 3; i++) begin
                if (reg_addr_i == ADDR_THERMAL_ALARM_N_LIM0 + 8'(i)) begin
                    thermal_limit[i] <= reg_wdata_i;
                end
            end
        end
    end

    // ****************************************************************
    // Status bits
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            an_st        <= '0;
            fan_st       <= '0;
            thermal_alarm_n_chg_st <= 1'b0;
            fan_evt_st   <= 1'b0;
            case_st      <= 1'b0;
        end else if (ce_i) begin
            an_st  <= next_an_st;
            fan_st <= next_fan_st;
            // Set beats the self-clear of a new cycle
            if (thermal_alarm_n_chg) begin
                thermal_alarm_n_chg_st <= 1'b1;
            end else if (monitor_cycle_i || rd_st1) begin
                thermal_alarm_n_chg_st <= 1'b0;
            end
            if (fan_start_stop_i && automatic_fan_regulation_i) begin
                fan_evt_st <= 1'b1;
            end else if (monitor_cycle_i || rd_st1) begin
                fan_evt_st <= 1'b0;
            end
            if (case_s[1]) begin
                case_st <= 1'b1;
            end else if (case_clr) begin
                case_st <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Interrupt latches and hold-off
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            an_latch  <= 1'b0;
            fan_latch <= 1'b0;
            evt_latch <= 1'b0;
            an_wait   <= 2'h0;
            fan_hold  <= 1'b0;
        end else if (ce_i) begin
            if (clear_any) begin
                an_latch  <= 1'b0;
                fan_latch <= 1'b0;
                evt_latch <= 1'b0;
                an_wait   <= LOCAL_TEMP_WAIT;
                fan_hold  <= 1'b1;
            end else begin
                if (an_wait != 2'h0) begin
                    if (local_temp_done_i) begin
                        an_wait <= an_wait - 2'h1;
                    end
                end else if (an_pend) begin
                    an_latch <= 1'b1;
                end
                if (fan_hold) begin
                    if (fan_cycle_end_i) begin
                        fan_hold <= 1'b0;
                    end
                end else if (fan_pend) begin
                    fan_latch <= 1'b1;
                end
            end
            // Set beats a clear in the same cycle; edge events fire only once
            if (evt_src) begin
                evt_latch <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Thermal alarm state and pin outputs
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            thermal_alarm_n_active           <= 1'b0;
            thermal_alarm_n_oe_n_o <= 1'b1;
            cooling_full_o         <= 1'b0;
            int_n_o                <= 1'b1;
        end else if (ce_i) begin
            if (thermal_alarm_n_set) begin
                thermal_alarm_n_active <= 1'b1;
            end else if (thermal_alarm_n_rel) begin
                thermal_alarm_n_active <= 1'b0;
            end
            thermal_alarm_n_oe_n_o <= !(thermal_alarm_n_active && !pin16_gp);
            cooling_full_o <= main_configuration[CFG_THERMAL_ALARM_N_EN] &&
                              (thermal_alarm_n_active || ext_low);
            int_n_o <= !int_on;
        end
    end
    assign thermal_alarm_n_o = 1'b0;

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire [7:0] st4 = {gp_live[PIN16], case_st, an_st[AN_SR4_BASE + 5], fan_evt_st,
                      thermal_alarm_n_chg_st, an_st[AN_SR4_BASE +: 3]};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_i)
            ADDR_MAIN_CFG:   rd_mux = main_configuration;
            ADDR_PIN_CFG3:   rd_mux = pin_configuration_three;
            ADDR_THERMAL_ALARM_N_LIM0: rd_mux = thermal_limit[0];
            ADDR_THERMAL_ALARM_N_LIM1: rd_mux = thermal_limit[1];
            ADDR_THERMAL_ALARM_N_LIM2: rd_mux = thermal_limit[2];
            ADDR_STATUS1:    rd_mux = an_st[7:0];
            ADDR_STATUS4:    rd_mux = st4;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_sel_i && !reg_we_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    assign analog_status_o  = an_st;
    assign fan_status_o     = fan_st;
    assign general_status_o = gp_live;
endmodule : tmi_thermal_monitor_interrupt

// ==== sim/tb.sv ====
// Self-checking testbench for the thermal monitor interrupt block
`timescale 1ns/10ps
module tb;
    import tmi_pkg::*;
    logic        clock_i = 0, rst_i = 1, ce_i = 1, ext_n = 1, monitor_cycle_i = 0;
    wire         reg_sel_i, reg_we_i, alert_response_i;
    wire  [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, fan_status_o;
    logic [7:0]  rd, fan_mask_i = 8'h00;
    tmi_meas_s   meas_i = '0;
    tmi_fan_s    fan_i = '0;
    logic        local_temp_done_i = 0, fan_cycle_end_i = 0, case_open_input_i = 0;
    logic        automatic_fan_regulation_i = 0, fan_start_stop_i = 0, temp_valid_i = 0;
    logic [23:0] temp_i = '0, analog_mask_i = '0;
    logic [16:0] general_mask_i = '0, general_dir_out_i = '0, general_polarity_i = '0;
    logic [16:0] general_pin_i = '1;
    wire         thermal_alarm_n_i, thermal_alarm_n_o, thermal_alarm_n_oe_n_o;
    wire         int_n_o, cooling_full_o;
    wire  [23:0] analog_status_o;
    wire  [16:0] general_status_o;
    int          bad_count = 0, num_checks = 0;
    always #5 clock_i = ~clock_i;
    // Alarm wire has a pull-up; device and bench may both pull it low
    assign thermal_alarm_n_i = (thermal_alarm_n_oe_n_o | thermal_alarm_n_o) & ext_n;
    tmi_thermal_monitor_interrupt dut (.*);
    tmi_host_model host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .sel_o(reg_sel_i),
        .we_o(reg_we_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .alert_o(alert_response_i));
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : wt
    task automatic mp(input logic [4:0] i, input logic [7:0] v);
        @(posedge clock_i) meas_i <= '{1'b1, i, v, 8'h20, 8'h10};
        @(posedge clock_i) meas_i.valid <= 1'b0;
    endtask : mp
    task automatic fp(input logic [7:0] c);
        @(posedge clock_i) fan_i <= '{1'b1, 3'd2, c, 8'h64};
        @(posedge clock_i) fan_i.valid <= 1'b0;
    endtask : fp
    task automatic tp(input logic [23:0] t);
        @(posedge clock_i) begin temp_i <= t; temp_valid_i <= 1'b1; end
        @(posedge clock_i) temp_valid_i <= 1'b0;
        wt(3);
    endtask : tp
    task automatic t_reset;
        chk("int_rst", 1, int_n_o);
        host.rd(ADDR_MAIN_CFG, rd); chk("cfg_rst", MAIN_CFG_RST, rd);
        host.rd(ADDR_THERMAL_ALARM_N_LIM0, rd); chk("lim_rst", THERMAL_ALARM_N_LIM_RST, rd);
        host.rd(8'hFF, rd); chk("unmapped", 0, rd);
        $display("reset test done");
    endtask : t_reset
    task automatic t_analog;
        host.wr(ADDR_MAIN_CFG, 8'h02);
        mp(5'd5, 8'h10); wt(3);
        chk("an_st", 24'h20, analog_status_o);
        chk("int_an", 0, int_n_o);
        host.rd(ADDR_STATUS1, rd); wt(1); chk("int_rd1", 1, int_n_o);
        mp(5'd5, 8'h21); wt(3); chk("int_hold", 1, int_n_o);
        repeat (2) begin
            @(posedge clock_i) local_temp_done_i <= 1'b1;
            @(posedge clock_i) local_temp_done_i <= 1'b0;
        end
        wt(3); chk("int_back", 0, int_n_o);
        mp(5'd5, 8'h15); wt(1); chk("an_self", 0, analog_status_o[5]);
        host.rd(ADDR_STATUS1, rd);
        $display("analog test done");
    endtask : t_analog
    task automatic t_fan;
        // End the hold-off left by the last status read
        @(posedge clock_i) fan_cycle_end_i <= 1'b1;
        @(posedge clock_i) fan_cycle_end_i <= 1'b0;
        fp(8'hC8); wt(3); chk("fan_st", 8'h04, fan_status_o);
        chk("int_fan", 0, int_n_o);
        host.alert; wt(2); chk("int_alert", 1, int_n_o);
        fp(8'hC8); wt(3); chk("fan_hold", 1, int_n_o);
        @(posedge clock_i) fan_cycle_end_i <= 1'b1;
        @(posedge clock_i) fan_cycle_end_i <= 1'b0;
        wt(3); chk("fan_back", 0, int_n_o);
        host.wr(ADDR_MAIN_CFG, 8'h06); wt(2); chk("int_clrbit", 1, int_n_o);
        host.wr(ADDR_MAIN_CFG, 8'h02); fp(8'h32); wt(1);
        chk("fan_ok", 0, fan_status_o);
        @(posedge clock_i) begin automatic_fan_regulation_i <= 1'b1; fan_start_stop_i <= 1'b1; end
        @(posedge clock_i) fan_start_stop_i <= 1'b0;
        wt(3); chk("int_afc", 0, int_n_o);
        host.rd(ADDR_STATUS1, rd); wt(4); chk("afc_once", 1, int_n_o);
        $display("fan test done");
    endtask : t_fan
    task automatic t_pins;
        @(posedge clock_i) general_pin_i <= 17'h1FFF7;
        wt(4); chk("gp_st", 17'h8, general_status_o);
        chk("int_gp", 0, int_n_o);
        host.rd(ADDR_STATUS1, rd); wt(1); chk("gp_noclr", 0, int_n_o);
        @(posedge clock_i) general_mask_i <= 17'h8;
        wt(2); chk("gp_mask", 1, int_n_o);
        @(posedge clock_i) begin general_mask_i <= '0; general_dir_out_i <= 17'h8; end
        wt(2); chk("gp_out", 1, int_n_o);
        @(posedge clock_i) begin general_dir_out_i <= '0; general_polarity_i <= 17'h8; end
        wt(2); chk("gp_pol", 0, general_status_o[3]);
        @(posedge clock_i) case_open_input_i <= 1'b1;
        wt(4); chk("int_case", 0, int_n_o);
        @(posedge clock_i) case_open_input_i <= 1'b0;
        host.rd(ADDR_STATUS4, rd); chk("case_st", 1, rd[ST4_CASE]);
        host.wr(ADDR_PIN_CFG3, 8'h02); host.wr(ADDR_PIN_CFG3, 8'h00);
        host.rd(ADDR_STATUS4, rd); chk("case_clr", 0, rd[ST4_CASE]);
        $display("pin test done");
    endtask : t_pins
    task automatic t_thermal_alarm_n;
        host.wr(ADDR_MAIN_CFG, 8'h12); host.rd(ADDR_STATUS1, rd);
        tp(24'h007000); chk("alarm_on", 0, thermal_alarm_n_oe_n_o);
        chk("cool_on", 1, cooling_full_o);
        chk("int_th", 0, int_n_o);
        host.rd(ADDR_STATUS4, rd); chk("th_chg", 1, rd[ST4_THERMAL_ALARM_N_CHG]);
        host.rd(ADDR_STATUS1, rd); wt(4); chk("th_edge", 1, int_n_o);
        tp(24'h006000); chk("th_hyst", 0, thermal_alarm_n_oe_n_o);
        tp(24'h005F00); chk("th_rel", 1, thermal_alarm_n_oe_n_o);
        chk("int_rel", 0, int_n_o);
        @(posedge clock_i) ext_n <= 1'b0;
        wt(4); chk("ext_cool", 1, cooling_full_o);
        host.wr(ADDR_PIN_CFG3, 8'h01); wt(4); chk("gp16_cool", 0, cooling_full_o);
        @(posedge clock_i) ext_n <= 1'b1;
        host.wr(ADDR_MAIN_CFG, 8'h02); host.rd(ADDR_STATUS1, rd);
        tp(24'h007000); chk("th_dis", 0, cooling_full_o);
        host.rd(ADDR_STATUS4, rd); chk("th_dis_st", 1, rd[ST4_THERMAL_ALARM_N_CHG]);
        @(posedge clock_i) monitor_cycle_i <= 1'b1;
        @(posedge clock_i) monitor_cycle_i <= 1'b0;
        host.rd(ADDR_STATUS4, rd); chk("th_self", 0, rd[ST4_THERMAL_ALARM_N_CHG]);
        $display("thermal test done");
    endtask : t_thermal_alarm_n
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        wt(1);
        t_reset; t_analog; t_fan; t_pins; t_thermal_alarm_n;
        stop_test;
    end
endmodule : tb

// ==== sim/tmi_host_model.sv ====
// Host controller model on the register port and alert response line
`timescale 1ns/10ps
module tmi_host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    output logic            sel_o = 1'b0,
    output logic            we_o = 1'b0,
    output logic [7:0]      addr_o = 8'h00,
    output logic [7:0]      wdata_o = 8'h00,
    output logic            alert_o = 1'b0
);
    // Released address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        sel_o <= 1'b1; we_o <= 1'b1; addr_o <= a; wdata_o <= d;
        @(posedge clock_i);
        sel_o <= 1'b0; addr_o <= ~a; wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        sel_o <= 1'b1; we_o <= 1'b0; addr_o <= a;
        @(posedge clock_i);
        sel_o <= 1'b0; addr_o <= ~a;
        #1 d = rdata_i;
    endtask : rd
    task automatic alert;
        @(posedge clock_i);
        alert_o <= 1'b1;
        @(posedge clock_i);
        alert_o <= 1'b0;
    endtask : alert
endmodule : tmi_host_model

// ==== sim/tmi_thermal_monitor_interrupt_assertions.sv ====
// Port-level checker for the thermal monitor interrupt block
`timescale 1ns/10ps
module tmi_checker
    import tmi_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        reg_sel_i,
    input wire logic        reg_we_i,
    input wire logic        temp_valid_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [7:0]  fan_status_o,
    input wire tmi_meas_s   meas_i,
    input wire tmi_fan_s    fan_i,
    input wire logic [16:0] general_pin_i,
    input wire logic [16:0] general_dir_out_i,
    input wire logic [16:0] general_polarity_i,
    input wire logic [16:0] general_status_o,
    input wire logic        thermal_alarm_n_o,
    input wire logic        thermal_alarm_n_oe_n_o,
    input wire logic        int_n_o,
    input wire logic        cooling_full_o,
    input wire logic [23:0] analog_status_o
);
    logic [7:0] cfg;
    wire rd1 = ce_i && reg_sel_i && !reg_we_i && reg_addr_i == ADDR_STATUS1;
    wire out_lim = meas_i.value > meas_i.high || meas_i.value <= meas_i.low;
    wire plain_ch = meas_i.index > 5'd1 && meas_i.index < 5'd24 && meas_i.index != 5'd16;
    // Shadow of main configuration, tracked from the write strobes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) cfg <= MAIN_CFG_RST;
        else if (ce_i && reg_sel_i && reg_we_i && reg_addr_i == ADDR_MAIN_CFG) cfg <= reg_wdata_i;
    end
    wire int_off = !cfg[CFG_INT_EN] || cfg[CFG_INT_CLR];
    wire cool_off = !cfg[CFG_THERMAL_ALARM_N_EN];
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_meas_set_bit: assert property (meas_i.valid && ce_i && !rd1
        && meas_i.index < 5'd24 && out_lim |=> analog_status_o[$past(meas_i.index)])
        else $error("status not set");
    a_meas_self_clear: assert property (meas_i.valid && ce_i && plain_ch && !out_lim
        |=> !analog_status_o[$past(meas_i.index)]) else $error("status not cleared");
    a_fan_store_bit: assert property (fan_i.valid && ce_i && !rd1 |=>
        fan_status_o[$past(fan_i.index)] == $past(fan_i.count > fan_i.limit))
        else $error("fan bit");
    a_read_clears_fan: assert property (rd1 && !fan_i.valid |=> fan_status_o == 8'h00)
        else $error("fan status kept after status read");
    a_unmapped_reads_zero: assert property (ce_i && reg_sel_i && !reg_we_i
        && reg_addr_i == 8'hFF |=> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");
    a_int_gated_off: assert property (int_off && $past(int_off)
        && $past(int_off, 2) |-> int_n_o) else $error("interrupt active while disabled");
    a_cool_gated_off: assert property (cool_off && $past(cool_off)
        && $past(cool_off, 2) |-> !cooling_full_o) else $error("cooling forced while disabled");
    a_alarm_forces_cool: assert property (!thermal_alarm_n_oe_n_o && $past(ce_i)
        && !$past(cool_off) |-> cooling_full_o) else $error("alarm drive without cooling");
    a_alarm_drive_low: assert property (thermal_alarm_n_o == 1'b0)
        else $error("alarm pin drives high");
    a_pin_status_set: assert property ((ce_i && !general_dir_out_i[3]
        && general_pin_i[3] == general_polarity_i[3])[*3] |-> general_status_o[3])
        else $error("pin status missing");
    c_meas: cover property (meas_i.valid && out_lim);
    c_fan: cover property (fan_i.valid && fan_i.count > fan_i.limit);
    c_int: cover property ($fell(int_n_o));
    c_thermal_alarm_n: cover property ($fell(thermal_alarm_n_oe_n_o));
endmodule : tmi_checker
bind tmi_thermal_monitor_interrupt tmi_checker chk (.*);
